// *** bench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	ces_pkg::ces_req_s req_i = '0;
	ces_pkg::ces_evt_s evt_i = '0;
	ces_pkg::ces_lvl_s lvl_i = '0;
	logic [3:0] psf_set_i = 4'h0;
	logic [3:0] psf_clr_i = 4'h0;
	logic [31:0] rdata_o;
	logic rvalid_o;
	logic irq_o;
	logic run_clear_o;
	int n_fail = 0;
	int cmp_count = 0;
	logic [31:0] d;

	ces_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
		.evt_i(evt_i), .lvl_i(lvl_i), .psf_set_i(psf_set_i), .psf_clr_i(psf_clr_i), .irq_o(irq_o),
		.run_clear_o(run_clear_o));

	always #50 clk_i = ~clk_i;

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic step();
		@(posedge clk_i);
		#1;
	endtask

	task automatic settle();
		step();
		step();
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		req_i.rd = 1'b1;
		req_i.addr = a;
		step();
		req_i.rd = 1'b0;
		check({31'h0, rvalid_o}, 32'h1);
		q = rdata_o;
		step();
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		req_i.wr = 1'b1;
		req_i.addr = a;
		req_i.wdata = v;
		step();
		req_i.wr = 1'b0;
		step();
	endtask

	// Read status, check it and the interrupt line, then write the value back
	task automatic chk(input logic [31:0] e);
		rd(ces_pkg::STAT_OFS, d);
		check(d, e);
		check({31'h0, irq_o}, {31'h0, |e[22:0]});
		wr(ces_pkg::STAT_OFS, d);
	endtask

	task automatic pulse(input ces_pkg::ces_evt_s v);
		evt_i = v;
		step();
		evt_i = '0;
	endtask

	task automatic t_reset();
		rd(ces_pkg::FCNT_OFS, d);
		check(d, 32'h0);
		rd(ces_pkg::STAT_OFS, d);
		check(d, 32'h0);
		rd(ces_pkg::MASK_OFS, d);
		check(d, 32'h0);
		wr(ces_pkg::STAT_OFS, 32'hffffffff);
		rd(ces_pkg::STAT_OFS, d);
		check(d, 32'h0);
		wr(12'h200, 32'hffffffff);
		rd(12'h200, d);
		check(d, 32'h0);
		$display("Test done: reset values");
	endtask

	task automatic t_events();
		int tb[18] = '{0, 2, 3, 3, -1, 8, 11, 12, 13, 14, 15, -1, 17, 17, 18, 18, 19, 19};
		ces_pkg::ces_evt_s v;
		wr(ces_pkg::MASK_OFS, 32'h007fffff);
		for (int k = 0; k < 18; k++) begin
			pulse(ces_pkg::ces_evt_s'(18'h1 << k));
			chk(tb[k] < 0 ? 32'h0 : 32'h1 << tb[k]);
		end
		lvl_i.parity_resp_en = 1'b1;
		v = '0;
		v.fetch_parity_err = 1'b1;
		pulse(v);
		check({31'h0, run_clear_o}, 32'h1);
		step();
		check({31'h0, run_clear_o}, 32'h0);
		chk(32'h00010000);
		lvl_i.parity_resp_en = 1'b0;
		$display("Test done: event flags");
	endtask

	task automatic t_unmask();
		ces_pkg::ces_evt_s v;
		wr(ces_pkg::MASK_OFS, 32'h0);
		v = '0;
		v.master_abort = 1'b1;
		pulse(v);
		check({31'h0, irq_o}, 32'h0);
		wr(ces_pkg::MASK_OFS, 32'h00020000);
		check({31'h0, irq_o}, 32'h1);
		wr(ces_pkg::STAT_OFS, 32'h00020000);
		check({31'h0, irq_o}, 32'h0);
		wr(ces_pkg::MASK_OFS, 32'h007fffff);
		$display("Test done: unmask pending");
	endtask

	task automatic t_levels();
		lvl_i.gp_edge_mode = 1'b1;
		lvl_i.line_lock = 1'b1;
		settle();
		chk(32'h00000010);
		lvl_i.line_lock = 1'b0;
		settle();
		chk(32'h00000010);
		lvl_i.video_present = 1'b1;
		settle();
		chk(32'h00000020);
		lvl_i.field_even = 1'b1;
		settle();
		chk(32'h01000002);
		lvl_i.capture_en = 2'b01;
		lvl_i.field_even = 1'b0;
		settle();
		chk(32'h00000002);
		lvl_i.capture_en = 2'b10;
		lvl_i.field_even = 1'b1;
		settle();
		chk(32'h01000002);
		rd(ces_pkg::FCNT_OFS, d);
		check(d, 32'h2);
		wr(ces_pkg::FCNT_OFS, 32'h5a);
		rd(ces_pkg::FCNT_OFS, d);
		check(d, 32'h0);
		lvl_i.line_reset_input = 1'b1;
		settle();
		chk(32'h01000004);
		lvl_i.line_reset_input = 1'b0;
		settle();
		chk(32'h01000000);
		lvl_i.gp_interrupt_pin = 1'b1;
		settle();
		chk(32'h01000200);
		chk(32'h01000000);
		lvl_i.gp_interrupt_pin = 1'b0;
		lvl_i.gp_edge_mode = 1'b0;
		lvl_i.gp_invert = 1'b1;
		settle();
		chk(32'h01000200);
		chk(32'h01000200);
		lvl_i.gp_invert = 1'b0;
		settle();
		chk(32'h01000200);
		chk(32'h01000000);
		$display("Test done: level events");
	endtask

	task automatic t_status();
		ces_pkg::ces_evt_s v;
		v = '0;
		v.serial_done = 1'b1;
		v.serial_ack = 1'b1;
		pulse(v);
		chk(32'h03000100);
		v.serial_ack = 1'b0;
		pulse(v);
		chk(32'h01000100);
		psf_set_i = 4'h5;
		step();
		psf_set_i = 4'h0;
		chk(32'h51000000);
		psf_clr_i = 4'h1;
		step();
		psf_clr_i = 4'h0;
		chk(32'h41000000);
		lvl_i.dma_active = 1'b1;
		settle();
		chk(32'h49000000);
		lvl_i.dma_active = 1'b0;
		settle();
		chk(32'h41000000);
		$display("Test done: status bits");
	endtask

	initial begin
		repeat (12) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		step();
		t_reset();
		t_events();
		t_unmask();
		t_levels();
		t_status();
		wrap_up();
	end

	// Watchdog: tests need well under 1000 cycles
	initial begin
		#(3000 * 100);
		n_fail++;
		wrap_up();
	end
endmodule

// *** design/ces_edge.sv ***
`timescale 1ns/1ns
module ces_edge #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Sampled levels
	input wire logic [W-1:0] d_i,
	// Edge pulses
	output logic [W-1:0] rise_o,
	output logic [W-1:0] chg_o
);
	logic [W-1:0] prev_r;

	if (W < 1) begin : g_chk
		$error("ces_edge: W must be at least 1");
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_r <= '0;
		end else begin
			prev_r <= d_i;
		end
	end

	assign rise_o = d_i & ~prev_r;
	assign chg_o = d_i ^ prev_r;
endmodule

// *** design/ces_flag.sv ***
`timescale 1ns/1ns
module ces_flag #(
	parameter int W = 23,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Set and clear per bit
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	// Sticky flags
	output logic [W-1:0] q_o
);
	if (W < 1) begin : g_chk
		$error("ces_flag: W must be at least 1");
	end

	for (genvar i = 0; i < W; i++) begin : g_bit
		// Set beats a clear in the same cycle
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				q_o[i] <= RST[i];
			end else if (set_i[i]) begin
				q_o[i] <= 1'b1;
			end else if (clr_i[i]) begin
				q_o[i] <= 1'b0;
			end
		end
	end
endmodule

// *** design/ces_pkg.sv ***
package ces_pkg;
	// Register offsets
	localparam logic [11:0] FCNT_OFS = 12'h0e8;
	localparam logic [11:0] STAT_OFS = 12'h100;
	localparam logic [11:0] MASK_OFS = 12'h104;
	// Widths
	localparam int CNT_W = 8;
	localparam int FLAG_W = 23;
	localparam int PSF_W = 4;
	// Values after reset
	localparam logic [7:0] FCNT_RST = 8'h00;
	localparam logic [22:0] MASK_RST = 23'h000000;
	localparam logic [22:0] FLAG_RST = 23'h000000;
	localparam logic [3:0] PSF_RST = 4'h0;
	// Sticky bits that software may clear
	localparam logic [22:0] FLAG_WR = 23'h0ffb3f;
	// Bit positions in the event status word
	localparam int B_FMT = 0;
	localparam int B_FCHG = 1;
	localparam int B_LINE = 2;
	localparam int B_CONV = 3;
	localparam int B_LOCK = 4;
	localparam int B_PRES = 5;
	localparam int B_SDONE = 8;
	localparam int B_GP = 9;
	localparam int B_PIRQ = 11;
	localparam int B_DROP = 12;
	localparam int B_LAT = 13;
	localparam int B_RESYNC = 14;
	localparam int B_BUS_PERR = 15;
	localparam int B_FPERR = 16;
	localparam int B_ABORT = 17;
	localparam int B_OPC = 18;
	localparam int B_SYNC = 19;
	localparam int B_FIELD = 24;
	localparam int B_ACK = 25;
	localparam int B_DMA = 27;
	localparam int B_PSF = 28;

	// Register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} ces_req_s;

	// One-cycle event pulses from the sources
	typedef struct packed {
		logic sync_ovf;
		logic sync_mismatch;
		logic bad_opcode;
		logic bad_sync_status;
		logic master_abort;
		logic target_abort;
		logic fetch_parity_err;
		logic parity_err;
		logic resync;
		logic overrun_latency;
		logic overrun_drop;
		logic instr_irq;
		logic serial_done;
		logic serial_ack;
		logic luma_ovf;
		logic chroma_ovf;
		logic line_start;
		logic fmt_change;
	} ces_evt_s;

	// Levels and configuration from the rest of the device
	typedef struct packed {
		logic video_present;
		logic line_lock;
		logic field_even;
		logic gp_interrupt_pin;
		logic line_reset_input;
		logic dma_active;
		logic parity_resp_en;
		logic gp_invert;
		logic gp_edge_mode;
		logic [1:0] capture_en;
	} ces_lvl_s;
endpackage

// *** design/ces_top.sv ***
`timescale 1ns/1ns
module ces_top #(
	parameter int CNT_W = ces_pkg::CNT_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register access
	input wire ces_pkg::ces_req_s req_i,
	output logic [31:0] rdata_o,
	output logic rvalid_o,
	// Event sources
	input wire ces_pkg::ces_evt_s evt_i,
	input wire ces_pkg::ces_lvl_s lvl_i,
	input wire logic [3:0] psf_set_i,
	input wire logic [3:0] psf_clr_i,
	// Outputs to the device
	output logic irq_o,
	output logic run_clear_o
);
	localparam int FW = ces_pkg::FLAG_W;

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [FW-1:0] mask_r;
	logic [FW-1:0] flags;
	logic [FW-1:0] set_v;
	logic [FW-1:0] clr_v;
	logic [3:0] psf_r;
	logic [3:0] psf_nxt;
	logic ack_rcvd_r;
	logic ack_rcvd_nxt;
	logic run_clear_r;
	logic [31:0] rdata_r;
	logic rvalid_r;
	logic [4:0] lvl_v;
	logic [4:0] rise;
	logic [4:0] chg;
	wire hit_fcnt;
	wire hit_stat;
	wire hit_mask;
	wire fcnt_wr;
	wire stat_wr;
	wire mask_wr;
	wire gp_in;
	wire gp_evt;
	wire field_chg;
	wire cnt_inc;
	wire fperr_hit;
	wire [31:0] stat_w;
	wire [31:0] rd_word;

	if (CNT_W < 1 || CNT_W > 24) begin : g_chk
		$error("ces_top: CNT_W must be 1 to 24");
	end

	// Address decode
	assign hit_fcnt = req_i.addr == ces_pkg::FCNT_OFS;
	assign hit_stat = req_i.addr == ces_pkg::STAT_OFS;
	assign hit_mask = req_i.addr == ces_pkg::MASK_OFS;
	assign fcnt_wr = req_i.wr & hit_fcnt;
	assign stat_wr = req_i.wr & hit_stat;
	assign mask_wr = req_i.wr & hit_mask;

	// Edge detection on incoming levels
	assign gp_in = lvl_i.gp_interrupt_pin ^ lvl_i.gp_invert;
	assign lvl_v = {lvl_i.line_reset_input, gp_in, lvl_i.field_even,
		lvl_i.line_lock, lvl_i.video_present};

	ces_edge #(
		.W(5)
	) u_edge (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i(lvl_v),
		.rise_o(rise),
		.chg_o(chg)
	);

	assign field_chg = chg[2];
	assign gp_evt = lvl_i.gp_edge_mode ? rise[3] : gp_in;
	assign fperr_hit = lvl_i.parity_resp_en & evt_i.fetch_parity_err;

	assign set_v[ces_pkg::B_FMT] = evt_i.fmt_change;
	assign set_v[ces_pkg::B_FCHG] = field_chg;
	assign set_v[ces_pkg::B_LINE] = evt_i.line_start | rise[4];
	assign set_v[ces_pkg::B_CONV] = evt_i.luma_ovf | evt_i.chroma_ovf;
	assign set_v[ces_pkg::B_LOCK] = chg[1];
	assign set_v[ces_pkg::B_PRES] = chg[0];
	assign set_v[7:6] = 2'h0;
	assign set_v[10] = 1'b0;
	assign set_v[22:20] = 3'h0;
	assign set_v[ces_pkg::B_SDONE] = evt_i.serial_done;
	assign set_v[ces_pkg::B_GP] = gp_evt;
	assign set_v[ces_pkg::B_PIRQ] = evt_i.instr_irq;
	assign set_v[ces_pkg::B_DROP] = evt_i.overrun_drop;
	assign set_v[ces_pkg::B_LAT] = evt_i.overrun_latency;
	assign set_v[ces_pkg::B_RESYNC] = evt_i.resync;
	assign set_v[ces_pkg::B_BUS_PERR] = evt_i.parity_err;
	assign set_v[ces_pkg::B_FPERR] = fperr_hit;
	assign set_v[ces_pkg::B_ABORT] = evt_i.master_abort | evt_i.target_abort;
	assign set_v[ces_pkg::B_OPC] = evt_i.bad_opcode | evt_i.bad_sync_status;
	assign set_v[ces_pkg::B_SYNC] = evt_i.sync_ovf | evt_i.sync_mismatch;

	assign clr_v = stat_wr ? (req_i.wdata[FW-1:0] & ces_pkg::FLAG_WR) : '0;

	ces_flag #(
		.W(FW),
		.RST(ces_pkg::FLAG_RST)
	) u_flag (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.set_i(set_v),
		.clr_i(clr_v),
		.q_o(flags)
	);

	assign cnt_inc = field_chg & |lvl_i.capture_en;
	// Write clears, keeping a same-cycle count
	assign cnt_nxt = fcnt_wr ? {{(CNT_W-1){1'b0}}, cnt_inc} : cnt_r + {{(CNT_W-1){1'b0}}, cnt_inc};
	assign psf_nxt = (psf_r & ~psf_clr_i) | psf_set_i;
	assign ack_rcvd_nxt = evt_i.serial_done ? evt_i.serial_ack : ack_rcvd_r;

	assign stat_w = {psf_r, lvl_i.dma_active, 1'b0, ack_rcvd_r, lvl_i.field_even, 1'b0, flags};
	assign rd_word = hit_fcnt ? {{(32-CNT_W){1'b0}}, cnt_r} :
		hit_stat ? stat_w :
		hit_mask ? {{(32-FW){1'b0}}, mask_r} : 32'h00000000;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= CNT_W'(ces_pkg::FCNT_RST);
			mask_r <= ces_pkg::MASK_RST;
			psf_r <= ces_pkg::PSF_RST;
			ack_rcvd_r <= 1'b0;
			run_clear_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			psf_r <= psf_nxt;
			ack_rcvd_r <= ack_rcvd_nxt;
			run_clear_r <= fperr_hit;
			if (mask_wr) begin
				mask_r <= req_i.wdata[FW-1:0];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_r <= 32'h00000000;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= req_i.rd;
			if (req_i.rd) begin
				rdata_r <= rd_word;
			end
		end
	end

	assign rdata_o = rdata_r;
	assign rvalid_o = rvalid_r;
	assign run_clear_o = run_clear_r;
	assign irq_o = |(flags & mask_r);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_cnt_write_clear: assert property (
		fcnt_wr && !cnt_inc |=> cnt_r == '0
	) else $error("counter not cleared by write");

	a_cnt_count_up: assert property (
		!fcnt_wr && cnt_inc |=> cnt_r == $past(cnt_r) + CNT_W'(1)
	) else $error("counter did not advance");

	a_cnt_idle_hold: assert property (
		!fcnt_wr && lvl_i.capture_en == 2'b00 |=> $stable(cnt_r)
	) else $error("counter moved without capture");

	a_flag_write_clear: assert property (
		stat_wr && req_i.wdata[ces_pkg::B_SDONE] && !evt_i.serial_done
		|=> !flags[ces_pkg::B_SDONE]
	) else $error("flag not cleared by write");

	a_flag_set_wins: assert property (
		stat_wr && evt_i.instr_irq |=> flags[ces_pkg::B_PIRQ]
	) else $error("event lost during clear");

	a_psf_set_reset: assert property (
		psf_clr_i != 4'h0 && psf_set_i == 4'h0
		|=> (psf_r & $past(psf_clr_i)) == 4'h0
	) else $error("program status not reset");

	a_dma_reads_zero: assert property (
		req_i.rd && hit_stat && !lvl_i.dma_active
		|=> rvalid_o && !rdata_o[ces_pkg::B_DMA]
	) else $error("dma bit set while disabled");

	a_ack_clear_nak: assert property (
		evt_i.serial_done && !evt_i.serial_ack
		|=> !ack_rcvd_r && flags[ces_pkg::B_SDONE]
	) else $error("ack bit kept after no-ack");

	a_field_reads_back: assert property (
		req_i.rd && hit_stat |=> rdata_o[ces_pkg::B_FIELD] == $past(lvl_i.field_even)
	) else $error("field bit mismatch");

	a_abort_sets: assert property (
		evt_i.master_abort || evt_i.target_abort |=> flags[ces_pkg::B_ABORT]
	) else $error("abort flag not set");

	a_fetch_parity_stop: assert property (
		fperr_hit |=> run_clear_o && flags[ces_pkg::B_FPERR]
	) else $error("fetch parity not handled");

	a_fetch_parity_gate: assert property (
		!lvl_i.parity_resp_en |=> !run_clear_o
	) else $error("run cleared without parity response");

	a_irq_unmasked: assert property (
		evt_i.line_start && mask_r[ces_pkg::B_LINE] && !mask_wr |=> irq_o
	) else $error("interrupt missing for unmasked flag");

	a_resv_zero: assert property (
		flags[22:20] == 3'h0 && flags[10] == 1'b0 && flags[7:6] == 2'h0
	) else $error("reserved status bit set");

	a_sync_err_sets: assert property (
		evt_i.sync_ovf || evt_i.sync_mismatch |=> flags[ces_pkg::B_SYNC]
	) else $error("sync count error not set");

	a_opcode_err_sets: assert property (
		evt_i.bad_opcode || evt_i.bad_sync_status |=> flags[ces_pkg::B_OPC]
	) else $error("opcode error not set");

	a_bus_parity_sets: assert property (
		evt_i.parity_err |=> flags[ces_pkg::B_BUS_PERR]
	) else $error("bus parity flag not set");

	a_resync_sets: assert property (
		evt_i.resync |=> flags[ces_pkg::B_RESYNC]
	) else $error("resync flag not set");

	a_overrun_lat_sets: assert property (
		evt_i.overrun_latency |=> flags[ces_pkg::B_LAT]
	) else $error("latency overrun flag not set");

	a_overrun_drop_sets: assert property (
		evt_i.overrun_drop |=> flags[ces_pkg::B_DROP]
	) else $error("drop overrun flag not set");

	a_conv_ovf_sets: assert property (
		evt_i.luma_ovf || evt_i.chroma_ovf |=> flags[ces_pkg::B_CONV]
	) else $error("converter overflow flag not set");

	a_fmt_chg_sets: assert property (
		evt_i.fmt_change |=> flags[ces_pkg::B_FMT]
	) else $error("format change flag not set");
endmodule
